/* hdl/tpw_timer.sv */
// Purpose: 16-bit free-running timer with pwm mode, event flags and one shared request
// Assumes: all pin inputs synchronous to aclk; halt_mode driven by the power controller
// Notes:   registers reached over axi4-lite; one-pulse detail not implemented
// Function
// - pwm output cycles; period from period compare, edge from pulse compare
// - in pwm both compares double buffered, loaded at period match
// - in pwm a period match reloads the counter with FFFCh
// - pin takes first level on pulse match, second level on period match
// - first=1, second=0 gives high pulse of period minus pulse compare
// - equal level bits give a constant pin level
// - period is compare plus five ticks; prescaler divides by 2, 4 or 8
// - high byte write suspends compare until low byte is written
// - pwm never sets either compare-match flag
// - pwm sets capture a flag at period match
// - pwm disconnects capture a pin; capture b still works
// - pwm and single pulse bits both set means pwm only
// - wait mode leaves timer running; enabled request wakes from wait
// - one shared request gated by three enables; never wakes from halt
// - three control/status registers and six 16-bit data registers
// - tick select 00 div4, 01 div2, 10 div8, 11 external clock
// - pin enable only routes output; compare keeps running otherwise
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`include "tpw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tpw_timer #(
	parameter int CW = 16
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write
	input  wire logic [`TPW_AW-1:0]    awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// axi4-lite read
	input  wire logic [`TPW_AW-1:0]    araddr,
	input  wire logic [2:0]            arprot,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// timer pins
	input  wire logic                  ext_clk_in,
	input  wire logic                  capture_a_pin,
	input  wire logic                  capture_b_pin,
	output logic                       wave_out_pin,
	output logic                       wave_out_oe_n,
	// power and interrupt
	input  wire logic                  halt_mode,
	output logic                       timer_irq,
	output logic                       wait_wake
);

	// register state
	tpw_pkg::tpw_ctrl1_t ctrl1, next_ctrl1;
	tpw_pkg::tpw_ctrl2_t ctrl2, next_ctrl2;
	tpw_pkg::tpw_flags_t flags, next_flags;
	logic [CW-1:0]       count, next_count;
	logic [CW-1:0]       cap_a, next_cap_a;
	logic [CW-1:0]       cap_b, next_cap_b;
	logic [CW-1:0]       cmp_sh [2];
	logic [CW-1:0]       next_cmp_sh [2];
	logic [CW-1:0]       cmp_act [2];
	logic [CW-1:0]       next_cmp_act [2];
	logic [1:0]          inhibit, next_inhibit;
	logic [2:0]          div_cnt, next_div_cnt;
	logic                wave, next_wave;
	logic                ext_prev, cap_a_prev, cap_b_prev, halt_prev;
	logic [1:0]          armed, next_armed;

	// bus state
	logic                next_bvalid, next_rvalid;
	logic [1:0]          next_bresp, next_rresp;
	logic [31:0]         next_rdata;

	// decoded events
	logic                wr_take, rd_take, pwm_on, tick, cmp_idx;
	logic                edge_a, edge_b, ext_edge;
	logic [2:0]          div_last;

	assign wr_take = awvalid && wvalid && !bvalid;
	assign rd_take = arvalid && !rvalid;
	assign awready = wr_take;
	assign wready  = wr_take;
	assign arready = rd_take;
	assign cmp_idx = (awaddr == `TPW_OFF_PERIOD_CMP);

	// pwm wins over single pulse, which then has no effect
	assign pwm_on = ctrl2.pwm_mode_bit;

	assign ext_edge = ctrl2.ext_edge_rising ? (ext_clk_in && !ext_prev) : (!ext_clk_in && ext_prev);
	assign edge_a   = ctrl1.edge_a_rising ? (capture_a_pin && !cap_a_prev)
	                                      : (!capture_a_pin && cap_a_prev);
	assign edge_b   = ctrl2.edge_b_rising ? (capture_b_pin && !cap_b_prev)
	                                      : (!capture_b_pin && cap_b_prev);

	always_comb
	begin
		unique case (ctrl2.tick_select)
			tpw_pkg::TPW_TICK_DIV4: div_last = `TPW_DIV4_LAST;
			tpw_pkg::TPW_TICK_DIV2: div_last = `TPW_DIV2_LAST;
			tpw_pkg::TPW_TICK_DIV8: div_last = `TPW_DIV8_LAST;
			tpw_pkg::TPW_TICK_EXT:  div_last = `TPW_DIV8_LAST;
		endcase
	end

	// halt stops every tick, so the count and the wave hold while halted
	assign tick = !halt_mode && ((ctrl2.tick_select == tpw_pkg::TPW_TICK_EXT) ? ext_edge
	                                                         : (div_cnt == div_last));

	// one level request; the cpu applies its own global mask
	assign timer_irq = (flags.capture_a_flag || flags.capture_b_flag) && ctrl1.capture_irq_enable
	                || (flags.match_a_flag || flags.match_b_flag) && ctrl1.match_irq_enable
	                || flags.overflow_flag && ctrl1.overflow_irq_enable;
	// the request reaches the wake logic only outside halt
	assign wait_wake = timer_irq && !halt_mode;

	assign wave_out_pin  = wave;
	// pin enable only routes the wave out; compares run regardless
	assign wave_out_oe_n = !ctrl2.wave_pin_enable;

	// timer and register next state
	always_comb
	begin
		tpw_pkg::tpw_flags_t set_f, clr_f;
		set_f        = '0;
		clr_f        = '0;
		next_ctrl1   = ctrl1;
		next_ctrl2   = ctrl2;
		next_count   = count;
		next_cap_a   = cap_a;
		next_cap_b   = cap_b;
		next_cmp_sh  = cmp_sh;
		next_cmp_act = cmp_act;
		next_inhibit = inhibit;
		next_wave    = wave;
		next_armed   = armed;
		next_div_cnt = div_cnt;

		if (wr_take)
		begin
			unique case (awaddr)
				`TPW_OFF_CTRL1: if (wstrb[0]) next_ctrl1 = wdata[7:0];
				`TPW_OFF_CTRL2: if (wstrb[0]) next_ctrl2 = wdata[7:0];
				`TPW_OFF_STATUS: if (wstrb[0]) clr_f = wdata[`TPW_STATUS_LSB +: 5];
				`TPW_OFF_PULSE_CMP, `TPW_OFF_PERIOD_CMP:
				begin
					if (wstrb[1])
					begin
						next_cmp_sh[cmp_idx][15:8] = wdata[15:8];
						next_inhibit[cmp_idx]      = 1'b1;
					end
					if (wstrb[0])
					begin
						next_cmp_sh[cmp_idx][7:0] = wdata[7:0];
						next_inhibit[cmp_idx]     = 1'b0;
						if (cmp_idx)
							clr_f.match_b_flag = 1'b1;
						else
							clr_f.match_a_flag = 1'b1;
					end
				end
				default: ;
			endcase
		end

		if (!halt_mode)
			next_div_cnt = (div_cnt == div_last) ? 3'h0 : div_cnt + 3'h1;

		if (tick)
		begin
			next_count = count + 16'h0001;
			if (count == 16'hFFFF)
				set_f.overflow_flag = 1'b1;
			if (pwm_on)
			begin
				if (!inhibit[1] && count == cmp_act[1])
				begin
					// period end: restart, second level, load buffered compares
					next_count           = `TPW_COUNT_RELOAD;
					next_wave            = ctrl1.second_level_bit;
					set_f.capture_a_flag = 1'b1;
					next_cmp_act         = next_cmp_sh;
				end
				else if (!inhibit[0] && count == cmp_act[0])
					next_wave = ctrl1.first_level_bit;
				// no match flag is raised while pwm runs
			end
			else
			begin
				if (!inhibit[0] && count == cmp_act[0])
				begin
					set_f.match_a_flag = 1'b1;
					next_wave          = ctrl1.first_level_bit;
				end
				if (!inhibit[1] && count == cmp_act[1])
					set_f.match_b_flag = 1'b1;
			end
		end

		// outside pwm the compare acts on the written value at once
		if (!pwm_on)
			next_cmp_act = next_cmp_sh;

		if (halt_mode)
		begin
			// edges during halt only arm the capture
			if (edge_a && !pwm_on)
				next_armed[0] = 1'b1;
			if (edge_b)
				next_armed[1] = 1'b1;
		end
		else
		begin
			if ((edge_a && !pwm_on) || (halt_prev && armed[0]))
			begin
				next_cap_a           = count;
				set_f.capture_a_flag = 1'b1;
			end
			if (edge_b || (halt_prev && armed[1]))
			begin
				next_cap_b           = count;
				set_f.capture_b_flag = 1'b1;
			end
			next_armed = 2'h0;
		end

		// a hardware set beats a clear in the same cycle
		next_flags = (flags & ~clr_f) | set_f;
		if (halt_mode)
			next_flags = flags;
	end

	// bus answer next state
	always_comb
	begin
		next_bvalid = bvalid && !bready;
		next_bresp  = bresp;
		next_rvalid = rvalid && !rready;
		next_rresp  = rresp;
		next_rdata  = rdata;
		if (wr_take)
		begin
			next_bvalid = 1'b1;
			unique case (awaddr)
				`TPW_OFF_CTRL1, `TPW_OFF_CTRL2, `TPW_OFF_STATUS,
				`TPW_OFF_PULSE_CMP, `TPW_OFF_PERIOD_CMP: next_bresp = `TPW_RESP_OKAY;
				default: next_bresp = `TPW_RESP_SLVERR;
			endcase
		end
		if (rd_take)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `TPW_RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			unique case (araddr)
				`TPW_OFF_CTRL1:      next_rdata[7:0] = ctrl1;
				`TPW_OFF_CTRL2:      next_rdata[7:0] = ctrl2;
				`TPW_OFF_STATUS:     next_rdata[`TPW_STATUS_LSB +: 5] = flags;
				`TPW_OFF_CAP_A:      next_rdata[15:0] = cap_a;
				`TPW_OFF_CAP_B:      next_rdata[15:0] = cap_b;
				`TPW_OFF_PULSE_CMP:  next_rdata[15:0] = cmp_sh[0];
				`TPW_OFF_PERIOD_CMP: next_rdata[15:0] = cmp_sh[1];
				`TPW_OFF_COUNT, `TPW_OFF_ALT_COUNT: next_rdata[15:0] = count;
				default:             next_rresp = `TPW_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl1      <= `TPW_CTRL_RESET;
			ctrl2      <= `TPW_CTRL_RESET;
			flags      <= '0;
			count      <= `TPW_COUNT_RELOAD;
			cap_a      <= 16'h0000;
			cap_b      <= 16'h0000;
			cmp_sh     <= '{`TPW_CMP_RESET, `TPW_CMP_RESET};
			cmp_act    <= '{`TPW_CMP_RESET, `TPW_CMP_RESET};
			inhibit    <= 2'h0;
			div_cnt    <= 3'h0;
			wave       <= 1'b0;
			armed      <= 2'h0;
			ext_prev   <= 1'b0;
			cap_a_prev <= 1'b0;
			cap_b_prev <= 1'b0;
			halt_prev  <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= `TPW_RESP_OKAY;
			rvalid     <= 1'b0;
			rresp      <= `TPW_RESP_OKAY;
			rdata      <= 32'h0000_0000;
		end
		else
		begin
			ctrl1      <= next_ctrl1;
			ctrl2      <= next_ctrl2;
			flags      <= next_flags;
			count      <= next_count;
			cap_a      <= next_cap_a;
			cap_b      <= next_cap_b;
			cmp_sh     <= next_cmp_sh;
			cmp_act    <= next_cmp_act;
			inhibit    <= next_inhibit;
			div_cnt    <= next_div_cnt;
			wave       <= next_wave;
			armed      <= next_armed;
			ext_prev   <= ext_clk_in;
			cap_a_prev <= capture_a_pin;
			cap_b_prev <= capture_b_pin;
			halt_prev  <= halt_mode;
			bvalid     <= next_bvalid;
			bresp      <= next_bresp;
			rvalid     <= next_rvalid;
			rresp      <= next_rresp;
			rdata      <= next_rdata;
		end
	end

endmodule // tpw_timer

`default_nettype wire

/* hdl/tpw_cfg.svh */
// Purpose: offsets, reset values and counts of the timer pwm block
// Assumes: 32-bit axi4-lite register bus, one word per register
// Notes:   definitions only
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH

`define TPW_AW            8
`define TPW_OFF_CTRL1     8'h00
`define TPW_OFF_CTRL2     8'h04
`define TPW_OFF_STATUS    8'h08
`define TPW_OFF_CAP_A     8'h0C
`define TPW_OFF_CAP_B     8'h10
`define TPW_OFF_PULSE_CMP 8'h14
`define TPW_OFF_PERIOD_CMP 8'h18
`define TPW_OFF_COUNT     8'h1C
`define TPW_OFF_ALT_COUNT 8'h20

`define TPW_STATUS_LSB    3
`define TPW_COUNT_RELOAD  16'hFFFC
`define TPW_CMP_RESET     16'h8000
`define TPW_CTRL_RESET    8'h00

`define TPW_DIV2_LAST     3'h1
`define TPW_DIV4_LAST     3'h3
`define TPW_DIV8_LAST     3'h7

`define TPW_RESP_OKAY     2'h0
`define TPW_RESP_SLVERR   2'h2

`endif

/* hdl/tpw_pkg.sv */
// Purpose: types of the timer pwm block
// Assumes: field layouts match the control and status words
// Notes:   the top bit of each struct is bit 7 of its register
package tpw_pkg;

	typedef enum logic [1:0] {
		TPW_TICK_DIV4,
		TPW_TICK_DIV2,
		TPW_TICK_DIV8,
		TPW_TICK_EXT
	} tpw_tick_t;

	typedef struct packed {
		logic       capture_irq_enable;
		logic       match_irq_enable;
		logic       overflow_irq_enable;
		logic [1:0] unused;
		logic       second_level_bit;
		logic       edge_a_rising;
		logic       first_level_bit;
	} tpw_ctrl1_t;

	typedef struct packed {
		logic       wave_pin_enable;
		logic       unused;
		logic       single_pulse_mode_bit;
		logic       pwm_mode_bit;
		tpw_tick_t  tick_select;
		logic       edge_b_rising;
		logic       ext_edge_rising;
	} tpw_ctrl2_t;

	typedef struct packed {
		logic capture_a_flag;
		logic capture_b_flag;
		logic overflow_flag;
		logic match_a_flag;
		logic match_b_flag;
	} tpw_flags_t;

endpackage

/* testbench/tpw_timer_checker.sv */
// Purpose: bus and pin relations of the timer pwm block
// Assumes: sees top-level ports only
// Notes:   bound to tpw_timer below
`timescale 1ns/1ps
`default_nettype none
module tpw_timer_checker (
	// clock, reset, bus
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic rvalid,
	// pins and power
	input wire logic wave_out_pin,
	input wire logic wave_out_oe_n,
	input wire logic halt_mode,
	input wire logic timer_irq,
	input wire logic wait_wake
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (awready |=> bvalid)
		else $error("write not answered");
	a_write_held: assert property (bvalid && !bready |=> bvalid)
		else $error("write answer dropped");
	a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
		else $error("read not answered");
	a_halt_freeze: assert property ($past(halt_mode) |-> $stable(wave_out_pin))
		else $error("wave moved in halt");
	a_no_halt_wake: assert property (halt_mode |-> !wait_wake)
		else $error("wake during halt");
	a_wait_wake: assert property (timer_irq && !halt_mode |-> wait_wake)
		else $error("no wake from wait");
	a_irq_held: assert property ($fell(timer_irq) |-> $past(awready))
		else $error("request fell without write");
	a_oe_by_write: assert property ($changed(wave_out_oe_n) |-> $past(awready))
		else $error("pin enable moved alone");
endmodule // tpw_timer_checker
bind tpw_timer tpw_timer_checker u_chk (.aclk, .aresetn, .awready, .bvalid, .bready,
	.arvalid, .rvalid, .wave_out_pin, .wave_out_oe_n, .halt_mode, .timer_irq, .wait_wake);
`default_nettype wire

/* testbench/tpw_pin_model.sv */
// Purpose: external pins around the timer: tick source and capture inputs
// Assumes: one capture pulse per kick
// Notes:   tick source stands still unless told to run
`timescale 1ns/1ps
`default_nettype none
module tpw_pin_model (
	// clock and commands
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ext_run,
	input  wire logic kick,
	// pins
	output logic      ext_clk_in,
	output logic      capture_a_pin,
	output logic      capture_b_pin
);
	always @(posedge aclk)
	begin
		ext_clk_in <= aresetn && ext_run && !ext_clk_in;
		capture_a_pin <= aresetn && kick;
		capture_b_pin <= aresetn && kick;
	end
endmodule // tpw_pin_model
`default_nettype wire

/* testbench/tb_timer_pwm_mode_and_events.sv */
// Purpose: register-level tests of the timer pwm block
// Assumes: axi4-lite master tasks, bus answer after one cycle
// Notes:   counts derived from compare values and tick rates
`include "tpw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pwm_mode_and_events;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, halt_mode = 0, ext_run = 0, kick = 0;
	logic        awready, wready, bvalid, arready, rvalid, timer_irq, wait_wake;
	logic        ext_clk_in, capture_a_pin, capture_b_pin, wave_out_pin, wave_out_oe_n;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [3:0]  wstrb = 0;
	logic [31:0] wdata = 0, rdata, rd_v, v1;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  c2 [5] = '{8'hB4, 8'h90, 8'h98, 8'h9D, 8'h9C};
	int          ml [5] = '{2, 4, 8, 2, 2};
	int          n_errors = 0, cmp_count = 0, hi, per;

	tpw_timer uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ext_clk_in, .capture_a_pin,
		.capture_b_pin, .wave_out_pin, .wave_out_oe_n, .halt_mode, .timer_irq, .wait_wake);
	tpw_pin_model pins (.aclk, .aresetn, .ext_run, .kick, .ext_clk_in, .capture_a_pin,
		.capture_b_pin);

	always #5 aclk = !aclk;

	task automatic print_verdict();
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h3);
		bit aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel is released on its own ready; bready stays up between calls
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				aw_done = 1'b1;
			if (wready === 1'b1)
				w_done = 1'b1;
			if (aw_done)
				awvalid <= 1'b0;
			if (w_done)
				wvalid <= 1'b0;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd_v = rdata;
		resp = rresp;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), rd_v, e);
	endtask

	// one rise-to-rise cycle of the wave, in aclk cycles
	task automatic meas();
		while (wave_out_pin !== 1'b0) @(posedge aclk);
		while (wave_out_pin !== 1'b1) @(posedge aclk);
		hi = 0;
		per = 0;
		while (wave_out_pin === 1'b1)
		begin
			@(posedge aclk);
			hi++;
		end
		while (wave_out_pin === 1'b0)
		begin
			@(posedge aclk);
			per++;
		end
		per += hi;
	endtask

	// all waits on the design end here if it hangs
	initial
	begin
		#300000;
		n_errors++;
		print_verdict();
	end

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(`TPW_OFF_CTRL1, 0);
		rc(`TPW_OFF_STATUS, 0);
		rc(`TPW_OFF_PULSE_CMP, 32'h8000);
		rc(`TPW_OFF_PERIOD_CMP, 32'h8000);
		chk("read ok", resp, `TPW_RESP_OKAY);
		rc(8'h40, 0);
		chk("read resp", resp, `TPW_RESP_SLVERR);
		wr(`TPW_OFF_COUNT, 0);
		chk("write resp", resp, `TPW_RESP_SLVERR);
		chk("oe idle", wave_out_oe_n, 1);
		wr(`TPW_OFF_PERIOD_CMP, 32'h10);
		chk("write ok", resp, `TPW_RESP_OKAY);
		wr(`TPW_OFF_PULSE_CMP, 32'h08);
		wr(`TPW_OFF_CTRL1, 32'h81);
		for (int i = 0; i < 5; i++)
		begin
			ext_run <= (i >= 3);
			wr(`TPW_OFF_CTRL2, {24'h0, c2[i]});
			meas();
			meas();
			chk("period", per, ml[i] * 21);
			chk("pulse", hi, ml[i] * 8);
		end
		ext_run <= 1'b0;
		wr(`TPW_OFF_CTRL2, 32'hB4);
		chk("oe on", wave_out_oe_n, 0);
		rd(`TPW_OFF_STATUS);
		chk("flags", rd_v & 32'h98, 32'h80);
		chk("irq", timer_irq, 1);
		// a pulse compare written just after a period match must wait a period
		wr(`TPW_OFF_PERIOD_CMP, 32'h20);
		meas();
		while (wave_out_pin !== 1'b0) @(posedge aclk);
		wr(`TPW_OFF_PULSE_CMP, 32'h18);
		meas();
		chk("old pulse", hi, 48);
		meas();
		chk("new pulse", hi, 16);
		chk("new period", per, 74);
		wr(`TPW_OFF_CTRL1, 32'h85);
		repeat (100) @(posedge aclk);
		repeat (150)
		begin
			@(posedge aclk);
			chk("level", wave_out_pin, 1);
		end
		wr(`TPW_OFF_PERIOD_CMP, 0, 4'h2);
		wr(`TPW_OFF_STATUS, 32'h80);
		repeat (150) @(posedge aclk);
		rd(`TPW_OFF_STATUS);
		chk("inhibit", rd_v[7], 0);
		// second reset: counter would need a full wrap otherwise
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wr(`TPW_OFF_PERIOD_CMP, 32'h10);
		wr(`TPW_OFF_PULSE_CMP, 32'h08);
		wr(`TPW_OFF_CTRL1, 32'h83);
		wr(`TPW_OFF_CTRL2, 32'h96);
		meas();
		kick <= 1'b1;
		@(posedge aclk);
		kick <= 1'b0;
		repeat (4) @(posedge aclk);
		rc(`TPW_OFF_CAP_A, 0);
		rd(`TPW_OFF_STATUS);
		chk("cap b", rd_v[6], 1);
		wr(`TPW_OFF_STATUS, 32'h40);
		halt_mode <= 1'b1;
		@(posedge aclk);
		rd(`TPW_OFF_COUNT);
		v1 = rd_v;
		kick <= 1'b1;
		@(posedge aclk);
		kick <= 1'b0;
		repeat (20) @(posedge aclk);
		rc(`TPW_OFF_COUNT, v1);
		rd(`TPW_OFF_STATUS);
		chk("armed", rd_v[6], 0);
		chk("halt wake", wait_wake, 0);
		halt_mode <= 1'b0;
		repeat (2) @(posedge aclk);
		rd(`TPW_OFF_STATUS);
		chk("exit flag", rd_v[6], 1);
		rc(`TPW_OFF_CAP_B, v1);
		chk("wait wake", wait_wake, 1);
		wr(`TPW_OFF_CTRL1, 32'h03);
		chk("irq off", timer_irq, 0);
		// pwm passes FFFFh every period, so the overflow flag stands
		wr(`TPW_OFF_CTRL1, 32'h20);
		chk("irq overflow", timer_irq, 1);
		wr(`TPW_OFF_CTRL1, 32'h40);
		chk("irq match", timer_irq, 0);
		print_verdict();
	end
endmodule // tb_timer_pwm_mode_and_events
`default_nettype wire
